// file: core/ingress_event_pkg.sv
// constants, field layouts and carriers for the ingress event selector
// assumes a single 100 MHz core clock shared with the event sources
package ingress_event_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 8;
  localparam int INC_W = CNT_W + 3;
  localparam int SEL_W = 16;
  localparam int ADDR_W = 12;
  localparam int NUM_CLS = 7;
  localparam int NUM_BYP = 4;
  localparam int MAX_CTR = 8;

  // ----------------------------------------------------------------
  // select register fields
  // ----------------------------------------------------------------
  localparam int CODE_LSB = 0;
  localparam int UMASK_LSB = 8;
  localparam logic [SEL_W-1:0] SEL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // register map: one word per counter in each region
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] SEL_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] INC_BASE = 12'h020;
  localparam int REGION_LSB = 5;
  localparam int IDX_LSB = 2;

  // ----------------------------------------------------------------
  // event codes
  // ----------------------------------------------------------------
  localparam logic [7:0] EVT_BYPASS = 8'h40;
  localparam logic [7:0] EVT_NE_VN0 = 8'h43;
  localparam logic [7:0] EVT_NE_VN1 = 8'h44;
  localparam logic [7:0] EVT_NOCRD_VN1 = 8'h48;
  localparam logic [7:0] EVT_NOREQ_VN0 = 8'h49;
  localparam logic [7:0] EVT_NOREQ_VN1 = 8'h4a;
  localparam logic [7:0] EVT_MISC = 8'h5f;
  localparam logic [7:0] EVT_OCC = 8'h60;

  // ----------------------------------------------------------------
  // unit mask bit positions
  // ----------------------------------------------------------------
  localparam int MISC_ANY_FIFO = 0;
  localparam int MISC_ANY_PATH = 1;
  localparam int MISC_VN0_NOCMP = 2;
  localparam int MISC_VN1_NOCMP = 3;
  localparam int MISC_LT1 = 4;
  localparam int MISC_LT2 = 5;
  localparam int OCC_VNA = 0;
  localparam int OCC_FIFO = 1;
  localparam int OCC_PATH = 2;
  localparam int OCC_TXQ = 3;
  localparam int OCC_CMP = 4;
  localparam int OCC_P1P_TOTAL = 5;
  localparam int OCC_P1P_FIFO = 6;
  localparam int OCC_CONSUMED = 7;
  localparam int BYPASS_LAST_CTR = 2;
  localparam logic [CNT_W-1:0] CMP_LOW1 = 8'h01;
  localparam logic [CNT_W-1:0] CMP_LOW2 = 8'h02;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CLS-1:0] noreq_vn0;
    logic [NUM_CLS-1:0] noreq_vn1;
    logic [NUM_CLS-1:0] nocrd_vn1;
    logic [NUM_CLS-1:0] ne_vn0;
    logic [NUM_CLS-1:0] ne_vn1;
    logic [NUM_BYP-1:0] bypass;
    logic bgf_any_fifo;
    logic bgf_any_path;
    logic vn0_no_cmp_crd;
    logic vn1_no_cmp_crd;
    logic [CNT_W-1:0] cmp_crd_avail;
    logic [CNT_W-1:0] vna_in_use;
    logic [CNT_W-1:0] flits_in_fifo;
    logic [CNT_W-1:0] flits_in_path;
    logic [CNT_W-1:0] txq_in_use;
    logic [CNT_W-1:0] cmp_in_use;
    logic [CNT_W-1:0] p1p_total;
    logic [CNT_W-1:0] p1p_fifo;
    logic [CNT_W-1:0] vna_consumed;
  } ingress_events_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage

// file: core/ingress_event_select.sv
// per-counter event selection and increment for the ingress path
// assumes event sources and counters share core_clk; apb slave inside
//
// How it works
// - code 0x49 counts net-zero cannot-request-while-other-wins cycles
// - code 0x4a counts the same condition for virtual network one
// - class mask bits 0..6: home, snoop, response, data rsp, wb, ncb, ncs
// - code 0x40 counts bypasses, at most 1 per cycle, counters 0-2 only
// - bypass mask picks slot0 idle, slot0 arb, slot1 merge, slot2 merge
// - code 0x5f mask bits 0,1: flit in crossing fifo, or fifo path
// - misc mask bits 2,3: net zero/one data rsp blocked, no credit
// - misc mask bits 4,5: completion credit count below 1, below 2
// - code 0x60 mask bit 0 adds remote shared credits in use
// - occupancy bits 1,2 add flits in crossing fifo, or fifo plus pipe
// - occupancy bits 3,4 add transmit queue and completion credits used
// - occupancy bits 5,6 add pump-one-pending totals, or fifo only
// - occupancy bit 7 adds shared credits consumed this cycle
// - code 0x43 counts net-zero ingress not-empty cycles per class
// - code 0x44 counts net-one ingress not-empty cycles per class
// - each counter selects independently, so several buffers track
// - code 0x48 counts net-one cycles blocked for lack of credits
`timescale 1ns/1ps

module ingress_event_select
  import ingress_event_pkg::*;
#(
  parameter int NUM_CTR = 4
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ingress_events_t events,
  output logic [NUM_CTR-1:0][INC_W-1:0] inc_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_CTR-1:0][SEL_W-1:0] sel;
    logic [NUM_CTR-1:0][INC_W-1:0] inc;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ----------------------------------------------------------------
  // increment for one counter
  // ----------------------------------------------------------------
  function automatic logic [INC_W-1:0] event_inc(
    input logic [SEL_W-1:0] sel,
    input ingress_events_t ev,
    input int idx
  );
    logic [7:0] code;
    logic [7:0] um;
    logic [INC_W-1:0] acc;
    logic hit;
    code = sel[CODE_LSB +: 8];
    um = sel[UMASK_LSB +: 8];
    acc = '0;
    hit = 1'b0;
    // condition events: selected sub-conditions ored
    case (code)
      EVT_NOREQ_VN0:
        hit = |(um[NUM_CLS-1:0] & ev.noreq_vn0);
      EVT_NOREQ_VN1:
        hit = |(um[NUM_CLS-1:0] & ev.noreq_vn1);
      EVT_NOCRD_VN1:
        hit = |(um[NUM_CLS-1:0] & ev.nocrd_vn1);
      EVT_NE_VN0:
        hit = |(um[NUM_CLS-1:0] & ev.ne_vn0);
      EVT_NE_VN1:
        hit = |(um[NUM_CLS-1:0] & ev.ne_vn1);
      EVT_BYPASS:
      begin
        // upper counters never see bypasses
        hit = (idx <= BYPASS_LAST_CTR) &&
              (|(um[NUM_BYP-1:0] & ev.bypass));
      end
      EVT_MISC:
      begin
        hit = (um[MISC_ANY_FIFO] & ev.bgf_any_fifo) |
              (um[MISC_ANY_PATH] & ev.bgf_any_path) |
              (um[MISC_VN0_NOCMP] & ev.vn0_no_cmp_crd) |
              (um[MISC_VN1_NOCMP] & ev.vn1_no_cmp_crd) |
              (um[MISC_LT1] & (ev.cmp_crd_avail < CMP_LOW1)) |
              (um[MISC_LT2] & (ev.cmp_crd_avail < CMP_LOW2));
      end
      EVT_OCC:
      begin
        // several occupancy bits add their sums; the adder has 3 guard bits
        if (um[OCC_VNA])
          acc = acc + INC_W'(ev.vna_in_use);
        if (um[OCC_FIFO])
          acc = acc + INC_W'(ev.flits_in_fifo);
        if (um[OCC_PATH])
          acc = acc + INC_W'(ev.flits_in_path);
        if (um[OCC_TXQ])
          acc = acc + INC_W'(ev.txq_in_use);
        if (um[OCC_CMP])
          acc = acc + INC_W'(ev.cmp_in_use);
        if (um[OCC_P1P_TOTAL])
          acc = acc + INC_W'(ev.p1p_total);
        if (um[OCC_P1P_FIFO])
          acc = acc + INC_W'(ev.p1p_fifo);
        if (um[OCC_CONSUMED])
          acc = acc + INC_W'(ev.vna_consumed);
      end
      default:
        acc = '0;
    endcase
    if (hit)
      acc = INC_W'(1);
    return acc;
  endfunction

  // ----------------------------------------------------------------
  // next state: apb slave plus per-counter increments
  // ----------------------------------------------------------------
  logic access;
  logic [2:0] idx;
  logic [ADDR_W-1:0] region;

  assign access = apb_req.psel && apb_req.penable && !s_q.pready;
  assign idx = apb_req.paddr[IDX_LSB +: 3];
  assign region = {apb_req.paddr[ADDR_W-1:REGION_LSB], 5'h00};

  always_comb
  begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (access)
    begin
      // one wait state keeps pready a plain flop
      s_d.pready = 1'b1;
      s_d.prdata = 32'h0000_0000;
      if (int'(idx) >= NUM_CTR || apb_req.paddr[1:0] != 2'b00)
        s_d.pslverr = 1'b1;
      else if (region == SEL_BASE)
      begin
        if (apb_req.pwrite)
          s_d.sel[idx] = apb_req.pwdata[SEL_W-1:0];
        else
          s_d.prdata = {16'h0000, s_q.sel[idx]};
      end
      else if (region == INC_BASE && !apb_req.pwrite)
        s_d.prdata = {{(32-INC_W){1'b0}}, s_q.inc[idx]};
      else
        s_d.pslverr = 1'b1;
    end
    // every counter has its own select
    for (int i = 0; i < NUM_CTR; i++)
      s_d.inc[i] = event_inc(s_q.sel[i], events, i);
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      s_q <= '0;
      for (int i = 0; i < NUM_CTR; i++)
        s_q.sel[i] <= SEL_RESET;
    end
    else
      s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign inc_out = s_q.inc;

  // ----------------------------------------------------------------
  // checks on counter 0 and the bypass restriction
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  logic [7:0] code0;
  logic [7:0] um0;
  assign code0 = s_q.sel[0][CODE_LSB +: 8];
  assign um0 = s_q.sel[0][UMASK_LSB +: 8];

  property p_noreq_vn0;
    (code0 == EVT_NOREQ_VN0 && um0 == 8'h01) |=>
      (inc_out[0] == INC_W'($past(events.noreq_vn0[0])));
  endproperty
  a_noreq_vn0: assert property (p_noreq_vn0)
    else $error("net zero cannot-request count wrong");

  property p_noreq_vn1;
    (code0 == EVT_NOREQ_VN1 && um0 == 8'h40 && events.noreq_vn1[6]) |=>
      (inc_out[0] == INC_W'(1));
  endproperty
  a_noreq_vn1: assert property (p_noreq_vn1)
    else $error("net one cannot-request missed");

  property p_class_mask;
    (code0 == EVT_NE_VN0 && um0[NUM_CLS-1:0] == 7'h00) |=>
      (inc_out[0] == '0);
  endproperty
  a_class_mask: assert property (p_class_mask)
    else $error("empty class mask still counts");

  property p_bypass_max;
    $past(code0 == EVT_BYPASS) |-> (inc_out[0] <= INC_W'(1));
  endproperty
  a_bypass_max: assert property (p_bypass_max)
    else $error("bypass increments above one");

  generate
    if (NUM_CTR > BYPASS_LAST_CTR + 1)
    begin : g_byp_chk
      property p_bypass_upper;
        (s_q.sel[NUM_CTR-1][CODE_LSB +: 8] == EVT_BYPASS) |=>
          (inc_out[NUM_CTR-1] == '0);
      endproperty
      a_bypass_upper: assert property (p_bypass_upper)
        else $error("bypass counted on an upper counter");
    end
  endgenerate

  property p_bypass_slot2;
    (code0 == EVT_BYPASS && um0 == 8'h08 && events.bypass[3]) |=>
      (inc_out[0] == INC_W'(1));
  endproperty
  a_bypass_slot2: assert property (p_bypass_slot2)
    else $error("slot two bypass missed");

  property p_misc_lt2;
    (code0 == EVT_MISC && um0 == 8'h20) |=>
      (inc_out[0] == INC_W'($past(events.cmp_crd_avail) < CMP_LOW2));
  endproperty
  a_misc_lt2: assert property (p_misc_lt2)
    else $error("credit below two count wrong");

  property p_misc_or;
    (code0 == EVT_MISC && um0 == 8'h0c &&
     events.vn0_no_cmp_crd && events.vn1_no_cmp_crd) |=>
      (inc_out[0] == INC_W'(1));
  endproperty
  a_misc_or: assert property (p_misc_or)
    else $error("ored conditions counted more than once");

  property p_occ_vna;
    (code0 == EVT_OCC && um0 == 8'h01) |=>
      (inc_out[0] == INC_W'($past(events.vna_in_use)));
  endproperty
  a_occ_vna: assert property (p_occ_vna)
    else $error("shared credit occupancy wrong");

  property p_occ_sum;
    (code0 == EVT_OCC && um0 == 8'h18) |=>
      (inc_out[0] == INC_W'($past(events.txq_in_use)) +
                     INC_W'($past(events.cmp_in_use)));
  endproperty
  a_occ_sum: assert property (p_occ_sum)
    else $error("credit occupancy sum wrong");

  sequence s_sel_write;
    apb_req.psel && apb_req.penable && apb_req.pwrite &&
    apb_req.paddr == SEL_BASE && !pready;
  endsequence

  property p_sel_write;
    s_sel_write ##1 pready |=>
      (code0 == $past(apb_req.pwdata[7:0], 2));
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select write did not take effect");

endmodule

// file: bench/perf_counter_model.sv
// far-side counters that accumulate the selector's increments
// assumes one increment word per counter per core_clk cycle
`timescale 1ns/1ps

module perf_counter_model
  import ingress_event_pkg::*;
#(
  parameter int N = 4
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [N-1:0][INC_W-1:0] inc,
  output logic [N-1:0][31:0] total
);
  // each counter adds only its own word
  always_ff @(posedge core_clk)
  begin
    for (int i = 0; i < N; i++)
    begin
      if (srst)
        total[i] <= 32'h0000_0000;
      else
        total[i] <= total[i] + 32'(inc[i]);
    end
  end
endmodule

// file: bench/ingress_event_select_tb.sv
// self-checking bench for the ingress event selector
// assumes apb answers after a bounded wait; 100 MHz core_clk
`timescale 1ns/1ps

module ingress_event_select_tb;
  import ingress_event_pkg::*;
  localparam int N = 4;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  apb_req_t req = '0;
  ingress_events_t ev = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [N-1:0][INC_W-1:0] inc_out;
  logic [N-1:0][31:0] total;
  logic [31:0] rd;
  logic er;
  int n_errors = 0;
  int checks = 0;

  ingress_event_select #(.NUM_CTR(N)) i_ingress_event_select (
    .core_clk(core_clk), .srst(srst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(ev), .inc_out(inc_out));
  perf_counter_model #(.N(N)) i_perf_counter_model (
    .core_clk(core_clk), .srst(srst), .inc(inc_out), .total(total));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // entered right after an edge; leaves one idle cycle after release
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge core_clk);
    end
    if (n >= 20)
      n_errors++;
    rd = prdata;
    er = pslverr;
    req <= '0;
    @(posedge core_clk);
  endtask

  task automatic set_sel(input int i, input logic [7:0] c,
                         input logic [7:0] m);
    apb(1'b1, SEL_BASE + 12'(4 * i), {16'h0000, m, c});
  endtask

  // one cycle from events to increment
  task automatic ev_chk(input int i, input ingress_events_t v,
                        input logic [INC_W-1:0] exp);
    ev <= v;
    @(posedge core_clk);
    #1 chk(32'(inc_out[i]), 32'(exp));
    @(posedge core_clk);
  endtask

  function automatic ingress_events_t cls_ev(input logic [7:0] c,
      input logic [6:0] own, input logic [6:0] oth);
    ingress_events_t e;
    e = '0;
    {e.noreq_vn0, e.noreq_vn1, e.nocrd_vn1, e.ne_vn0, e.ne_vn1} = {5{oth}};
    case (c)
      EVT_NOREQ_VN0: e.noreq_vn0 = own;
      EVT_NOREQ_VN1: e.noreq_vn1 = own;
      EVT_NOCRD_VN1: e.nocrd_vn1 = own;
      EVT_NE_VN0: e.ne_vn0 = own;
      default: e.ne_vn1 = own;
    endcase
    return e;
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < N; i++)
    begin
      apb(1'b0, SEL_BASE + 12'(4 * i), 32'h0000_0000);
      chk(rd, 32'(SEL_RESET));
      chk(32'(inc_out[i]), 32'h0000_0000);
    end
    $display("test reset done");
  endtask

  task automatic t_classes();
    logic [7:0] codes [5] = '{EVT_NOREQ_VN0, EVT_NOREQ_VN1,
                              EVT_NOCRD_VN1, EVT_NE_VN0, EVT_NE_VN1};
    logic [6:0] b;
    foreach (codes[c])
      for (int k = 0; k < NUM_CLS; k++)
      begin
        b = 7'(1 << k);
        set_sel(0, codes[c], {1'b0, b});
        ev_chk(0, cls_ev(codes[c], b, 7'h00), 1);
        ev_chk(0, cls_ev(codes[c], ~b, b), 0);
      end
    set_sel(0, EVT_NE_VN1, 8'h7f);
    ev_chk(0, cls_ev(EVT_NE_VN1, 7'h41, 7'h00), 1);
    $display("test classes done");
  endtask

  task automatic t_bypass();
    ingress_events_t e;
    e = '0;
    e.bypass = 4'hf;
    for (int i = 0; i < N; i++)
      set_sel(i, EVT_BYPASS, 8'h0f);
    for (int i = 0; i < N; i++)
      ev_chk(i, e, (i <= BYPASS_LAST_CTR) ? 11'd1 : 11'd0);
    for (int k = 0; k < NUM_BYP; k++)
    begin
      set_sel(0, EVT_BYPASS, 8'(1 << k));
      e.bypass = 4'(1 << k);
      ev_chk(0, e, 1);
      e.bypass = ~4'(1 << k);
      ev_chk(0, e, 0);
    end
    $display("test bypass done");
  endtask

  task automatic t_misc();
    ingress_events_t e;
    e = '0;
    e.cmp_crd_avail = 8'h05;
    for (int k = 0; k < 4; k++)
    begin
      set_sel(0, EVT_MISC, 8'(1 << k));
      {e.vn1_no_cmp_crd, e.vn0_no_cmp_crd, e.bgf_any_path,
       e.bgf_any_fifo} = 4'(1 << k);
      ev_chk(0, e, 1);
      {e.vn1_no_cmp_crd, e.vn0_no_cmp_crd, e.bgf_any_path,
       e.bgf_any_fifo} = ~4'(1 << k);
      ev_chk(0, e, 0);
    end
    e = '0;
    for (int k = 0; k < 2; k++)
    begin
      set_sel(0, EVT_MISC, 8'(8'h10 << k));
      e.cmp_crd_avail = 8'(k);
      ev_chk(0, e, 1);
      e.cmp_crd_avail = 8'(k + 1);
      ev_chk(0, e, 0);
    end
    $display("test misc done");
  endtask

  task automatic t_occ();
    ingress_events_t e;
    e = '0;
    {e.vna_in_use, e.flits_in_fifo, e.flits_in_path, e.txq_in_use,
     e.cmp_in_use, e.p1p_total, e.p1p_fifo, e.vna_consumed} =
      64'h1122_3344_5566_7788;
    for (int k = 0; k < 8; k++)
    begin
      set_sel(0, EVT_OCC, 8'(1 << k));
      ev_chk(0, e, 11'(17 * (k + 1)));
    end
    set_sel(0, EVT_OCC, 8'hff);
    e = '1;
    ev_chk(0, e, 11'd2040);
    $display("test occupancy done");
  endtask

  task automatic t_apb();
    logic [ADDR_W-1:0] bad [4] = '{12'h010, 12'h002, INC_BASE, 12'h040};
    set_sel(1, 8'hff, 8'hff);
    apb(1'b1, SEL_BASE + 12'h004, 32'hffff_ffff);
    apb(1'b0, SEL_BASE + 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_ffff);
    foreach (bad[k])
    begin
      apb(k != 3, bad[k], 32'hffff_ffff);
      chk(32'(er), 32'h0000_0001);
    end
    apb(1'b0, SEL_BASE, 32'h0000_0000);
    chk(rd, 32'h0000_ffff & 32'h0000_ff60);
    $display("test apb done");
  endtask

  task automatic t_multi();
    ingress_events_t e;
    logic [31:0] t0;
    logic [31:0] t1;
    e = '0;
    e.ne_vn0 = 7'h01;
    e.vna_in_use = 8'h03;
    ev <= e;
    set_sel(0, EVT_NE_VN0, 8'h01);
    set_sel(1, EVT_OCC, 8'h01);
    @(posedge core_clk);
    t0 = total[0];
    t1 = total[1];
    repeat (10) @(posedge core_clk);
    chk(total[0] - t0, 32'd10);
    chk(total[1] - t1, 32'd30);
    apb(1'b0, INC_BASE + 12'h004, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    $display("test multi done");
  endtask

  initial
  begin
    #100000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  initial
  begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_classes();
    t_bypass();
    t_misc();
    t_occ();
    t_apb();
    t_multi();
    conclude();
  end
endmodule
